// File: dbst_tap.sv
// One test access port: controller, instruction, bypass and id registers
`timescale 1ns/10ps
`include "dbst_defs.svh"
module dbst_tap
	import dbst_pkg::*;
#(
	parameter logic [31:0] ID_CODE = 32'h1234_5001, // Arbitrary neutral value
	parameter int          N       = `DBST_BSR_LEN
) (
	input  wire logic         tck,
	input  wire logic         trst_n,
	input  wire dbst_serial_t ser,
	output logic              tdo,
	output logic              tdo_en_n,
	input  wire logic [N-1:0] pin_in,
	input  wire logic [N-1:0] core_out,
	output logic [N-1:0]      pin_out,
	output logic              test_mode
);
	dbst_state_t st_q;
	dbst_state_t st_d;
	logic [3:0]  ir_sh_q;
	logic [3:0]  ir_q;
	logic        byp_q;
	logic [31:0] id_q;
	logic        bsr_so;
	logic        sel_bsr;
	logic        sel_id;
	logic        ser_d;
	dbst_ctl_t   ctl;
	// Sixteen-state controller next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			DBST_TLR:  st_d = ser.mode_select ? DBST_TLR  : DBST_RTI;
			DBST_RTI:  st_d = ser.mode_select ? DBST_SDRS : DBST_RTI;
			DBST_SDRS: st_d = ser.mode_select ? DBST_SIRS : DBST_CDR;
			DBST_CDR:  st_d = ser.mode_select ? DBST_E1DR : DBST_SDR;
			DBST_SDR:  st_d = ser.mode_select ? DBST_E1DR : DBST_SDR;
			DBST_E1DR: st_d = ser.mode_select ? DBST_UDR  : DBST_PDR;
			DBST_PDR:  st_d = ser.mode_select ? DBST_E2DR : DBST_PDR;
			DBST_E2DR: st_d = ser.mode_select ? DBST_UDR  : DBST_SDR;
			DBST_UDR:  st_d = ser.mode_select ? DBST_SDRS : DBST_RTI;
			DBST_SIRS: st_d = ser.mode_select ? DBST_TLR  : DBST_CIR;
			DBST_CIR:  st_d = ser.mode_select ? DBST_E1IR : DBST_SIR;
			DBST_SIR:  st_d = ser.mode_select ? DBST_E1IR : DBST_SIR;
			DBST_E1IR: st_d = ser.mode_select ? DBST_UIR  : DBST_PIR;
			DBST_PIR:  st_d = ser.mode_select ? DBST_E2IR : DBST_PIR;
			DBST_E2IR: st_d = ser.mode_select ? DBST_UIR  : DBST_SIR;
			DBST_UIR:  st_d = ser.mode_select ? DBST_SDRS : DBST_RTI;
			default:   st_d = DBST_TLR;
		endcase
	end
	// Controller state, forced to reset asynchronously
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			st_q <= DBST_TLR;
		end else begin
			st_q <= st_d;
		end
	end
	// Instruction shift stage
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_sh_q <= `DBST_IR_CAPTURE;
		end else if (st_q == DBST_CIR) begin
			ir_sh_q <= `DBST_IR_CAPTURE;
		end else if (st_q == DBST_SIR) begin
			ir_sh_q <= {ser.data_in, ir_sh_q[3:1]};
		end
	end
	// Active instruction; reset state loads the id instruction
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_q <= `DBST_OP_IDCODE;
		end else if (st_q == DBST_TLR) begin
			ir_q <= `DBST_OP_IDCODE;
		end else if (st_q == DBST_UIR) begin
			ir_q <= ir_sh_q;
		end
	end
	// Decode; any unknown opcode behaves as bypass
	assign sel_bsr = (ir_q == `DBST_OP_EXTEST) || (ir_q == `DBST_OP_SAMPLE);
	assign sel_id  = (ir_q == `DBST_OP_IDCODE);
	assign ctl.capture_dr = sel_bsr && (st_q == DBST_CDR);
	assign ctl.shift_dr   = sel_bsr && (st_q == DBST_SDR);
	assign ctl.update_dr  = sel_bsr && (st_q == DBST_UDR);
	// Clamp keeps pins on the update stage while bypass is in the path
	assign ctl.ext_drive  = (ir_q == `DBST_OP_EXTEST) || (ir_q == `DBST_OP_CLAMP);
	assign test_mode = ctl.ext_drive;
	// Single-bit bypass register
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			byp_q <= 1'b0;
		end else if (st_q == DBST_CDR) begin
			byp_q <= 1'b0;
		end else if (st_q == DBST_SDR) begin
			byp_q <= ser.data_in;
		end
	end
	// Identification register: capture code, shift bit 0 out first
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			id_q <= '0;
		end else if (sel_id && st_q == DBST_CDR) begin
			id_q <= ID_CODE;
		end else if (sel_id && st_q == DBST_SDR) begin
			id_q <= {ser.data_in, id_q[31:1]};
		end
	end
	dbst_bsr #(.N(N)) u_bsr (
		.tck      (tck),
		.trst_n   (trst_n),
		.ctl      (ctl),
		.scan_in  (ser.data_in),
		.pin_in   (pin_in),
		.core_out (core_out),
		.scan_out (bsr_so),
		.pin_out  (pin_out)
	);
	// Serial path mux
	always_comb begin
		if (st_q == DBST_SIR) begin
			ser_d = ir_sh_q[0];
		end else if (sel_bsr) begin
			ser_d = bsr_so;
		end else if (sel_id) begin
			ser_d = id_q[0];
		end else begin
			ser_d = byp_q;
		end
	end
	// Data out changes on falling edge; enabled only while shifting
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo      <= 1'b0;
			tdo_en_n <= 1'b1;
		end else begin
			tdo      <= ser_d;
			tdo_en_n <= !((st_q == DBST_SDR) || (st_q == DBST_SIR));
		end
	end
	a_tlr_loads_id: assert property (@(posedge tck) disable iff (!trst_n)
		st_q == DBST_TLR |=> (ir_q == `DBST_OP_IDCODE))
		else $error("reset state did not select id");
	a_five_ones_reset: assert property (@(posedge tck) disable iff (!trst_n)
		ser.mode_select [*5] |=> st_q == DBST_TLR)
		else $error("five ones did not reach reset");
	a_id_capture: assert property (@(posedge tck) disable iff (!trst_n)
		(sel_id && st_q == DBST_CDR) |=> id_q == ID_CODE)
		else $error("id code not captured");
	a_bypass_delay: assert property (@(posedge tck) disable iff (!trst_n)
		(!sel_bsr && !sel_id && st_q == DBST_SDR) |=> byp_q == $past(ser.data_in))
		else $error("bypass bit wrong");
	a_id_shift: assert property (@(posedge tck) disable iff (!trst_n)
		(sel_id && st_q == DBST_SDR) |=> id_q[31] == $past(ser.data_in))
		else $error("id shift wrong");
	a_clamp_drive: assert property (@(posedge tck) disable iff (!trst_n)
		(ir_q == `DBST_OP_CLAMP) |-> (test_mode && !sel_bsr))
		else $error("clamp path wrong");
	a_sample_func: assert property (@(posedge tck) disable iff (!trst_n)
		(ir_q == `DBST_OP_SAMPLE) |-> pin_out == core_out)
		else $error("sample disturbed pins");
	a_extest_drive: assert property (@(posedge tck) disable iff (!trst_n)
		(ir_q == `DBST_OP_EXTEST) |-> test_mode)
		else $error("extest not driving");
	c_id_shift: cover property (@(posedge tck) disable iff (!trst_n) sel_id && st_q == DBST_SDR);
	c_ir_update: cover property (@(posedge tck) disable iff (!trst_n) st_q == DBST_UIR);
	c_extest: cover property (@(posedge tck) disable iff (!trst_n) ir_q == `DBST_OP_EXTEST);
endmodule

// File: dbst_defs.svh
// Constants for the dual boundary-scan test access ports
`ifndef DBST_DEFS_SVH
`define DBST_DEFS_SVH
`define DBST_IR_LEN      4
`define DBST_OP_EXTEST   4'h0
`define DBST_OP_SAMPLE   4'h1
`define DBST_OP_IDCODE   4'h2
`define DBST_OP_CLAMP    4'h3
`define DBST_OP_BYPASS   4'hF
`define DBST_IR_CAPTURE  4'h1
`define DBST_ID_LEN      32
`define DBST_BSR_LEN     8
`endif

// File: dbst_pkg.sv
// Types shared by the dual boundary-scan test access ports
package dbst_pkg;
	typedef enum logic [3:0] {
		DBST_TLR  = 4'hF, DBST_RTI  = 4'hC, DBST_SDRS = 4'h7, DBST_CDR  = 4'h6,
		DBST_SDR  = 4'h2, DBST_E1DR = 4'h1, DBST_PDR  = 4'h3, DBST_E2DR = 4'h0,
		DBST_UDR  = 4'h5, DBST_SIRS = 4'h4, DBST_CIR  = 4'hE, DBST_SIR  = 4'hA,
		DBST_E1IR = 4'h9, DBST_PIR  = 4'hB, DBST_E2IR = 4'h8, DBST_UIR  = 4'hD
	} dbst_state_t;
	typedef struct packed {
		logic mode_select;
		logic data_in;
	} dbst_serial_t;
	typedef struct packed {
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
		logic ext_drive;
	} dbst_ctl_t;
endpackage

// File: dbst_bsr.sv
// Boundary scan register chain with latched update stage
`timescale 1ns/10ps
`include "dbst_defs.svh"
module dbst_bsr
	import dbst_pkg::*;
#(
	parameter int N = `DBST_BSR_LEN
) (
	input  wire logic         tck,
	input  wire logic         trst_n,
	input  wire dbst_ctl_t    ctl,
	input  wire logic         scan_in,
	input  wire logic [N-1:0] pin_in,
	input  wire logic [N-1:0] core_out,
	output logic              scan_out,
	output logic [N-1:0]      pin_out
);
	logic [N-1:0] shift_q;
	logic [N-1:0] upd_q;
	// Capture pin values or shift toward data out
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			shift_q <= '0;
		end else if (ctl.capture_dr) begin
			shift_q <= pin_in;
		end else if (ctl.shift_dr) begin
			shift_q <= {scan_in, shift_q[N-1:1]};
		end
	end
	// Update stage latches preload on falling edge so pins never ripple
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			upd_q <= '0;
		end else if (ctl.update_dr) begin
			upd_q <= shift_q;
		end
	end
	assign scan_out = shift_q[0];
	// Pins follow the core unless external test drive is selected
	assign pin_out = ctl.ext_drive ? upd_q : core_out;
endmodule

// File: dbst_dual.sv
// Dual boundary-scan logic: separate encoder and decoder test ports
// Notes on behaviour
// - Two separate five-pin test ports
// - Bypass puts one bit between in/out
// - External test drives and observes pins
// - Sample captures pins, function undisturbed
// - Sample allows shifting and preload
// - Clamp selects bypass, pins held driven
// - Id instruction gives maker, part, version
// - Controller rests in reset during function
// - Reset state loads id instruction
// - Low test reset forces reset asynchronously
// - Id selects identification register path
// - Capture loads code, then shifts out
// - Identification register is 32 bits
// - Bit 0 shifted out first
`timescale 1ns/10ps
`include "dbst_defs.svh"
module dbst_dual
	import dbst_pkg::*;
#(
	parameter logic [31:0] ENC_ID = 32'h1234_5001, // Arbitrary neutral value
	parameter logic [31:0] DEC_ID = 32'h1234_6001, // Arbitrary neutral value
	parameter int          N      = `DBST_BSR_LEN
) (
	input  wire logic         enc_test_clock,
	input  wire logic         enc_test_reset_n,
	input  wire logic         enc_test_mode_select,
	input  wire logic         enc_test_data_in,
	output logic              enc_test_data_out,
	output logic              enc_test_data_out_en_n,
	input  wire logic [N-1:0] enc_pin_in,
	input  wire logic [N-1:0] enc_core_out,
	output logic [N-1:0]      enc_pin_out,
	output logic              enc_test_mode,
	input  wire logic         dec_test_clock,
	input  wire logic         dec_test_reset_n,
	input  wire logic         dec_test_mode_select,
	input  wire logic         dec_test_data_in,
	output logic              dec_test_data_out,
	output logic              dec_test_data_out_en_n,
	input  wire logic [N-1:0] dec_pin_in,
	input  wire logic [N-1:0] dec_core_out,
	output logic [N-1:0]      dec_pin_out,
	output logic              dec_test_mode
);
	// Two independent ports, each on its own clock and reset
	dbst_tap #(.ID_CODE(ENC_ID), .N(N)) u_enc (
		.tck       (enc_test_clock),
		.trst_n    (enc_test_reset_n),
		.ser       ({enc_test_mode_select, enc_test_data_in}),
		.tdo       (enc_test_data_out),
		.tdo_en_n  (enc_test_data_out_en_n),
		.pin_in    (enc_pin_in),
		.core_out  (enc_core_out),
		.pin_out   (enc_pin_out),
		.test_mode (enc_test_mode)
	);
	dbst_tap #(.ID_CODE(DEC_ID), .N(N)) u_dec (
		.tck       (dec_test_clock),
		.trst_n    (dec_test_reset_n),
		.ser       ({dec_test_mode_select, dec_test_data_in}),
		.tdo       (dec_test_data_out),
		.tdo_en_n  (dec_test_data_out_en_n),
		.pin_in    (dec_pin_in),
		.core_out  (dec_core_out),
		.pin_out   (dec_pin_out),
		.test_mode (dec_test_mode)
	);
endmodule

// File: dbst_ctlr_model.sv
// Board test controller model for one serial test port
`timescale 1ns/10ps
module dbst_ctlr_model #(
	parameter int HALF = 50
) (
	output logic      tck,
	output logic      trst_n,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// Test clock rests low outside frames; it is not free running
	// Reset pin idles high so that every pull low is a clean falling edge
	initial begin
		tck = 1'b0;
		trst_n = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One clock; out level is taken at the rising edge, as the real tester does
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#HALF;
		o = tdo;
		tck = 1'b1;
		#HALF;
		tck = 1'b0;
	endtask
	// Power-up reset through the reset pin, held eight clock periods
	task automatic init();
		#HALF;
		trst_n = 1'b0;
		#(16*HALF);
		trst_n = 1'b1;
	endtask
	// Five ones reach the reset state from anywhere
	task automatic tlr();
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
	endtask
	// Idle, capture, shift n bits first bit first, update, idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b0, 1'b0, o);
		step(1'b1, 1'b0, o);
		if (ir) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule

// File: tb_dual_boundary_scan_tap.sv
// Testbench for the dual boundary-scan test ports
`timescale 1ns/10ps
module tb_dual_boundary_scan_tap;
	import dbst_pkg::*;
	localparam logic [31:0] ENC_ID = 32'h1234_5001; // Arbitrary value
	localparam logic [31:0] DEC_ID = 32'h1234_6001; // Arbitrary value
	logic [1:0]      tck, trst_n, tms, tdi, tdo, en_n, tmode;
	logic [1:0][7:0] pin_in, core_out, pin_out;
	logic [31:0]     d;
	int              n_mismatch = 0;
	int              n_tests = 0;
	int              n_en [2] = '{0, 0};
	// Rising edges that see data out enabled, per port
	always @(posedge tck[0]) begin
		if (en_n[0] === 1'b0) n_en[0]++;
	end
	always @(posedge tck[1]) begin
		if (en_n[1] === 1'b0) n_en[1]++;
	end
	// Encoder port at 100 ns, decoder port at 80 ns
	dbst_ctlr_model #(.HALF(50)) enc_m (.tck(tck[0]), .trst_n(trst_n[0]), .tms(tms[0]),
		.tdi(tdi[0]), .tdo(tdo[0]));
	dbst_ctlr_model #(.HALF(40)) dec_m (.tck(tck[1]), .trst_n(trst_n[1]), .tms(tms[1]),
		.tdi(tdi[1]), .tdo(tdo[1]));
	dbst_dual #(.ENC_ID(ENC_ID), .DEC_ID(DEC_ID), .N(8)) DUT (
		.enc_test_clock(tck[0]), .enc_test_reset_n(trst_n[0]),
		.enc_test_mode_select(tms[0]), .enc_test_data_in(tdi[0]),
		.enc_test_data_out(tdo[0]), .enc_test_data_out_en_n(en_n[0]),
		.enc_pin_in(pin_in[0]), .enc_core_out(core_out[0]),
		.enc_pin_out(pin_out[0]), .enc_test_mode(tmode[0]),
		.dec_test_clock(tck[1]), .dec_test_reset_n(trst_n[1]),
		.dec_test_mode_select(tms[1]), .dec_test_data_in(tdi[1]),
		.dec_test_data_out(tdo[1]), .dec_test_data_out_en_n(en_n[1]),
		.dec_pin_in(pin_in[1]), .dec_core_out(core_out[1]),
		.dec_pin_out(pin_out[1]), .dec_test_mode(tmode[1]));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Port selection keeps each scenario written once for both ports
	task automatic scan(input int p, input logic ir, input int n, input logic [31:0] din);
		int n0;
		n0 = n_en[p];
		if (p == 1) dec_m.scan(ir, n, din, d);
		else enc_m.scan(ir, n, din, d);
		check(32'(n_en[p] - n0), 32'(n));
	endtask
	// Reset pin, then the default path must be the identification code
	task automatic t_idcode(input int p, input logic [31:0] id);
		if (p == 1) dec_m.init();
		else enc_m.init();
		check(32'(tmode[p]), 32'h0);
		check(32'(en_n[p]), 32'h1);
		check(32'(pin_out[p]), 32'(core_out[p]));
		scan(p, 1'b0, 32, 32'h0);
		check(d, id);
	endtask
	// Bypass, an unused opcode and clamp all give a one-bit path
	task automatic t_bypass(input int p);
		logic [3:0] ops [3] = '{4'hF, 4'h7, 4'h3};
		foreach (ops[i]) begin
			scan(p, 1'b1, 4, 32'(ops[i]));
			check(d, 32'h1);
			scan(p, 1'b0, 8, 32'hA5);
			check(d, 32'h4A);
		end
	endtask
	// Sample, preload, external test, clamp, then back to reset by mode select
	task automatic t_bsr(input int p, input logic [31:0] id);
		pin_in[p] = 8'h3C;
		core_out[p] = 8'hC3;
		scan(p, 1'b1, 4, 32'h1);
		scan(p, 1'b0, 8, 32'h96);
		check(d, 32'h3C);
		check(32'({tmode[p], pin_out[p]}), 32'h0C3);
		scan(p, 1'b1, 4, 32'h0);
		check(32'({tmode[p], pin_out[p]}), 32'h196);
		pin_in[p] = 8'h5A;
		scan(p, 1'b0, 8, 32'h0F);
		check(d, 32'h5A);
		check(32'(pin_out[p]), 32'h0F);
		scan(p, 1'b1, 4, 32'h3);
		scan(p, 1'b0, 8, 32'h81);
		check(d, 32'h02);
		check(32'({tmode[p], pin_out[p]}), 32'h10F);
		if (p == 1) dec_m.tlr();
		else enc_m.tlr();
		check(32'({tmode[p], pin_out[p]}), 32'h0C3);
		scan(p, 1'b0, 32, 32'h0);
		check(d, id);
		// Mid-run reset pin while pins are driven must restore function
		scan(p, 1'b1, 4, 32'h0);
		check(32'(tmode[p]), 32'h1);
		if (p == 1) dec_m.init();
		else enc_m.init();
		check(32'({en_n[p], tmode[p], pin_out[p]}), 32'h2C3);
		scan(p, 1'b0, 32, 32'h0);
		check(d, id);
	endtask
	// Main sequence
	initial begin
		pin_in = '0;
		core_out = '0;
		for (int p = 0; p < 2; p++) begin
			t_idcode(p, p == 1 ? DEC_ID : ENC_ID);
			t_bypass(p);
			t_bsr(p, p == 1 ? DEC_ID : ENC_ID);
		end
		summarize();
	end
	// Watchdog: a hang counts as a mismatch
	initial begin
		#2000000;
		n_mismatch++;
		summarize();
	end
endmodule
